// ### tcc_defines.svh
// Notes on behaviour
// - Control bit 15 enables each comparator; clear disables it.
// - Control bit 14 routes the comparator result to its own pin.
// - Control bit 13 inverts the output polarity.
// - Event flag bit 9 sets on event, blocks retrigger until software clears.
// - Bits 7-6 pick events: off, rising, falling, or any change.
// - After arming, the first event fires on any output transition.
// - Bit 4 picks the non-inverting input: pin A or internal reference.
// - Bits 1-0 pick the inverting input: pin B, C, D or band gap.
// - Status bit 15 halts all comparators while the device is idle.
// - Status bits 10-8 mirror event flags of units 3, 2, 1.
// - Status bits 2-0 mirror result bits of units 3, 2, 1.
// - Unimplemented bits read zero and ignore writes.
// - Reference level field bits 4-0 gives 32 steps of the span.
// - Reference bit 5 picks supply rails or external reference pins span.
// - Reference bit 10 picks external pin or ladder, when bit 4 set.
// - Bits 9-8 pick band gap source, only when channel field is 11.
// - Reference bit 7 powers the reference generator.
// - Reference bit 6 connects the generated level to its pin, only while bit 7 powers the generator.
// - The result pin carries the unsynchronised comparator result after polarity, held low while the unit is disabled or halted.
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TCC_ADDR_CTRL1 4'h0
`define TCC_ADDR_CTRL2 4'h1
`define TCC_ADDR_CTRL3 4'h2
`define TCC_ADDR_STAT 4'h3
`define TCC_ADDR_REF 4'h4

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TCC_C_EN 15
`define TCC_C_OE 14
`define TCC_C_INV 13
`define TCC_C_EVT 9
`define TCC_C_RES 8
`define TCC_C_EDGE_HI 7
`define TCC_C_EDGE_LO 6
`define TCC_C_NINV 4
`define TCC_C_CH_HI 1
`define TCC_C_CH_LO 0
`define TCC_C_WMASK 16'he0d3
`define TCC_C_STORE_MASK 16'he0d3

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define TCC_S_IDLE 15
`define TCC_S_EVT_LO 8
`define TCC_S_RES_LO 0

// ----------------------------------------
// Reference register fields
// ----------------------------------------
`define TCC_R_EXT 10
`define TCC_R_BG_HI 9
`define TCC_R_BG_LO 8
`define TCC_R_PWR 7
`define TCC_R_PIN 6
`define TCC_R_SPAN 5
`define TCC_R_LVL_HI 4
`define TCC_R_WMASK 16'h07ff

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TCC_RST_WORD 16'h0000

`endif

// ### tcc_pkg.sv
package tcc_pkg;
  // Event edge selection
  typedef enum logic [1:0] {
    EDGE_OFF = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_ANY = 2'h3
  } tcc_edge_type;
  // Inverting input selection
  typedef enum logic [1:0] {
    INV_PIN_B = 2'h0,
    INV_PIN_C = 2'h1,
    INV_PIN_D = 2'h2,
    INV_BANDGAP = 2'h3
  } tcc_inv_type;
  // Per-unit arming state, one-hot
  typedef enum logic [2:0] {
    ARM_IDLE = 3'b001,
    ARM_FIRST = 3'b010,
    ARM_EDGE = 3'b100
  } tcc_arm_type;
endpackage : tcc_pkg

// ### tcc_triple_comparator_control.sv
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tcc_triple_comparator_control #(
  parameter int UNITS = 3
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [15:0] regRdData,
  input wire logic deviceIdle,
  input wire logic [UNITS-1:0] analogCompare,
  output logic [UNITS-1:0] compEnable,
  output logic [UNITS-1:0] resultPin,
  output logic [UNITS-1:0] resultPinOe,
  output logic [UNITS-1:0] noninvInputSelect,
  output logic [1:0] invInputSelect [UNITS],
  output logic [UNITS-1:0] eventPulse,
  output logic externalRefSelect,
  output logic [1:0] bandgapSourceSelect,
  output logic refPowerOn,
  output logic refPinOutput,
  output logic refSpanSelect,
  output logic [4:0] refLevel
);
  import tcc_pkg::*;

  // ----------------------------------------
  // Shared register state
  // ----------------------------------------
  logic idleHalt_q;
  logic idleHalt_d;
  logic [15:0] refCtrl_q;
  logic [15:0] refCtrl_d;
  logic [15:0] readWord_q;
  logic [15:0] readWord_d;
  logic [UNITS-1:0] resultBit;
  logic [UNITS-1:0] eventFlag;
  logic [15:0] ctrlWord [UNITS];
  logic running;

  // Comparators run unless idle halts them
  // A halted unit looks disabled: its result drops and events are gated
  assign running = !(idleHalt_q && deviceIdle);

  // ----------------------------------------
  // Per-comparator logic
  // ----------------------------------------
  for (genvar u = 0; u < UNITS; u++) begin : gUnit
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic stable_q;
    logic stable_d;
    logic evt_q;
    logic evt_d;
    tcc_arm_type arm_q;
    tcc_arm_type arm_d;
    logic active;
    logic polarised;
    logic rise;
    logic fall;
    logic hit;
    logic wrSel;
    tcc_edge_type edgeSel;

    assign wrSel = regWrStb && (regAddr == 4'(u));
    assign active = ctrl_q[`TCC_C_EN] && running;
    // Polarity applied to the analog decision
    assign polarised = analogCompare[u] ^ ctrl_q[`TCC_C_INV];
    assign edgeSel = tcc_edge_type'(ctrl_q[`TCC_C_EDGE_HI:`TCC_C_EDGE_LO]);
    assign rise = stable_q == 1'b0 && sync_q[2] == 1'b1 && sync_q[1] == 1'b1;
    assign fall = stable_q == 1'b1 && sync_q[2] == 1'b0 && sync_q[1] == 1'b0;

    // Synchroniser and edge qualified by two agreeing stages
    // Stage one feeds only stage two, so metastability cannot spread
    // Edges come from the filtered value, so a slow crossing counts once
    always_comb begin
      sync_d = {sync_q[1:0], polarised & active};
      stable_d = stable_q;
      if (sync_q[2] == sync_q[1]) begin
        stable_d = sync_q[2];
      end
    end

    // Event arming and hit detection
    always_comb begin
      arm_d = arm_q;
      hit = 1'b0;
      case (arm_q)
        ARM_IDLE: begin
          if (edgeSel != EDGE_OFF) begin
            arm_d = ARM_FIRST;
          end
        end
        ARM_FIRST: begin
          hit = rise | fall;
          if (edgeSel == EDGE_OFF) begin
            arm_d = ARM_IDLE;
          end else if (hit && !evt_q && active) begin
            // Leave first-any only once that event has really been taken
            arm_d = ARM_EDGE;
          end
        end
        ARM_EDGE: begin
          case (edgeSel)
            EDGE_RISE: hit = rise;
            EDGE_FALL: hit = fall;
            EDGE_ANY: hit = rise | fall;
            default: hit = 1'b0;
          endcase
          if (edgeSel == EDGE_OFF) begin
            arm_d = ARM_IDLE;
          end
        end
        default: arm_d = ARM_IDLE;
      endcase
    end

    // Control word and sticky flag, a hardware set wins over a write only while the flag is clear
    // A clear that meets a hardware event in one cycle wins the race, as the set flag blocks the event,
    // so software loses an event that arrives in the cycle it acknowledges the last one
    always_comb begin
      ctrl_d = ctrl_q;
      evt_d = evt_q;
      if (wrSel) begin
        ctrl_d = regWrData & `TCC_C_WMASK;
        evt_d = regWrData[`TCC_C_EVT];
      end
      if (hit && !evt_q && active) begin
        evt_d = 1'b1;
      end
    end

    // Registers of one unit
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        ctrl_q <= `TCC_RST_WORD;
        sync_q <= 3'h0;
        stable_q <= 1'b0;
        evt_q <= 1'b0;
        arm_q <= ARM_IDLE;
      end else begin
        ctrl_q <= ctrl_d;
        sync_q <= sync_d;
        stable_q <= stable_d;
        evt_q <= evt_d;
        arm_q <= arm_d;
      end
    end

    // Outputs of one unit
    assign resultBit[u] = stable_q;
    assign eventFlag[u] = evt_q;
    assign eventPulse[u] = hit && !evt_q && active;
    assign compEnable[u] = active;
    assign resultPinOe[u] = ctrl_q[`TCC_C_OE];
    assign resultPin[u] = polarised & active;
    assign noninvInputSelect[u] = ctrl_q[`TCC_C_NINV];
    assign invInputSelect[u] = ctrl_q[`TCC_C_CH_HI:`TCC_C_CH_LO];
    assign ctrlWord[u] = ctrl_q | {6'h00, evt_q, stable_q, 8'h00};
  end

  // ----------------------------------------
  // Status and reference registers
  // ----------------------------------------
  always_comb begin
    idleHalt_d = idleHalt_q;
    refCtrl_d = refCtrl_q;
    if (regWrStb && regAddr == `TCC_ADDR_STAT) begin
      idleHalt_d = regWrData[`TCC_S_IDLE];
    end
    if (regWrStb && regAddr == `TCC_ADDR_REF) begin
      refCtrl_d = regWrData & `TCC_R_WMASK;
    end
  end

  // Read multiplexer, data in the cycle after the strobe
  always_comb begin
    readWord_d = 16'h0000;
    if (regRdStb) begin
      case (regAddr)
        `TCC_ADDR_CTRL1: readWord_d = ctrlWord[0];
        `TCC_ADDR_CTRL2: readWord_d = ctrlWord[1];
        `TCC_ADDR_CTRL3: readWord_d = ctrlWord[2];
        `TCC_ADDR_STAT: begin
          readWord_d[`TCC_S_IDLE] = idleHalt_q;
          readWord_d[`TCC_S_EVT_LO +: 3] = eventFlag[2:0];
          readWord_d[`TCC_S_RES_LO +: 3] = resultBit[2:0];
        end
        `TCC_ADDR_REF: readWord_d = refCtrl_q;
        default: readWord_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      idleHalt_q <= 1'b0;
      refCtrl_q <= `TCC_RST_WORD;
      readWord_q <= 16'h0000;
    end else begin
      idleHalt_q <= idleHalt_d;
      refCtrl_q <= refCtrl_d;
      readWord_q <= readWord_d;
    end
  end

  // ----------------------------------------
  // Reference generator controls
  // ----------------------------------------
  assign regRdData = readWord_q;
  assign externalRefSelect = refCtrl_q[`TCC_R_EXT];
  assign bandgapSourceSelect = refCtrl_q[`TCC_R_BG_HI:`TCC_R_BG_LO];
  assign refPowerOn = refCtrl_q[`TCC_R_PWR];
  assign refPinOutput = refCtrl_q[`TCC_R_PIN] & refCtrl_q[`TCC_R_PWR];
  assign refSpanSelect = refCtrl_q[`TCC_R_SPAN];
  assign refLevel = refCtrl_q[`TCC_R_LVL_HI:0];
endmodule : tcc_triple_comparator_control

// ### tcc_monitor.sv
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tcc_monitor #(
  parameter int UNITS = 3
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [15:0] regRdData,
  input wire logic deviceIdle,
  input wire logic [UNITS-1:0] compEnable,
  input wire logic [UNITS-1:0] resultPinOe,
  input wire logic [UNITS-1:0] eventPulse,
  input wire logic refPinOutput,
  input wire logic refPowerOn,
  input wire logic [4:0] refLevel
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic haltQ;
  logic wrCtl;
  logic wrRef;
  logic rdCtl;
  logic rdStat;
  assign wrCtl = regWrStb && regAddr == `TCC_ADDR_CTRL1;
  assign wrRef = regWrStb && regAddr == `TCC_ADDR_REF;
  assign rdCtl = regRdStb && regAddr < `TCC_ADDR_STAT;
  assign rdStat = regRdStb && regAddr == `TCC_ADDR_STAT;
  // Shadow of the idle halt bit
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      haltQ <= 1'b0;
    end else if (regWrStb && regAddr == `TCC_ADDR_STAT) begin
      haltQ <= regWrData[`TCC_S_IDLE];
    end
  end
  AST_RD_QUIET: assert property (!$past(regRdStb) |-> regRdData == 16'h0)
    else $error("read data outside its cycle");
  AST_CTRL_ZERO: assert property (rdCtl |=>
    (regRdData & 16'h1c2c) == 16'h0000) else $error("control gap bits set");
  AST_STAT_ZERO: assert property (rdStat |=>
    (regRdData & 16'h78f8) == 16'h0000) else $error("status gap bits set");
  AST_ENABLE: assert property (wrCtl |=> compEnable[0] ==
    ($past(regWrData[`TCC_C_EN]) && !(deviceIdle && haltQ)))
    else $error("enable wrong");
  AST_PIN_OE: assert property (wrCtl |=>
    resultPinOe[0] == $past(regWrData[`TCC_C_OE]))
    else $error("pin enable wrong");
  AST_IDLE_HALT: assert property (deviceIdle && haltQ |->
    compEnable == '0) else $error("unit runs while halted");
  AST_REF_LEVEL: assert property (wrRef |=>
    refLevel == $past(regWrData[4:0])) else $error("level wrong");
  AST_REF_POWER: assert property (wrRef |=>
    refPowerOn == $past(regWrData[`TCC_R_PWR])) else $error("power wrong");
  AST_REF_PIN: assert property (wrRef |=> refPinOutput ==
    ($past(regWrData[`TCC_R_PIN]) && $past(regWrData[`TCC_R_PWR])))
    else $error("reference pin wrong");
  AST_PULSE_ONCE: assert property ((eventPulse & $past(eventPulse)) == '0)
    else $error("event repeats while flag set");
  AST_PULSE_GATED: assert property ((eventPulse & ~compEnable) == '0)
    else $error("event from a stopped unit");
  cover property (eventPulse[1]);
  cover property (eventPulse[2]);
  cover property (deviceIdle && haltQ);
  cover property (regRdStb && regAddr == `TCC_ADDR_STAT);
endmodule : tcc_monitor
bind tcc_triple_comparator_control tcc_monitor #(.UNITS(UNITS)) i_mon (
  .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdData(regRdData), .deviceIdle(deviceIdle), .compEnable(compEnable),
  .resultPinOe(resultPinOe), .eventPulse(eventPulse),
  .refPinOutput(refPinOutput), .refPowerOn(refPowerOn), .refLevel(refLevel)
);

// ### tcc_analog_model.sv
`timescale 1ns/1ps
module tcc_analog_model (
  input wire logic [2:0] level,
  output logic [2:0] analogCompare = 3'h0
);
  // Decisions settle a few ns after the inputs move, off the clock
  always @(level) begin
    analogCompare <= #3 level;
  end
endmodule : tcc_analog_model

// ### tcc_triple_comparator_control_test.sv
`timescale 1ns/1ps
module tcc_triple_comparator_control_test;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic deviceIdle = 1'b0;
  logic [2:0] level = 3'h0;
  logic [15:0] regRdData;
  logic [15:0] c;
  logic [2:0] analogCompare;
  logic [2:0] compEnable;
  logic [2:0] resultPin;
  logic [2:0] resultPinOe;
  logic [2:0] noninvInputSelect;
  logic [1:0] invInputSelect [3];
  logic [2:0] eventPulse;
  logic externalRefSelect;
  logic [1:0] bandgapSourceSelect;
  logic refPowerOn;
  logic refPinOutput;
  logic refSpanSelect;
  logic [4:0] refLevel;
  logic [15:0] refBits;
  logic [15:0] ctlBits;
  int hits = 0;
  int fails = 0;
  int nTests = 0;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  always #5 clock = ~clock;
  tcc_analog_model i_model (.level(level), .analogCompare(analogCompare));
  tcc_triple_comparator_control i_dut (
    .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .deviceIdle(deviceIdle),
    .analogCompare(analogCompare), .compEnable(compEnable),
    .resultPin(resultPin), .resultPinOe(resultPinOe),
    .noninvInputSelect(noninvInputSelect),
    .invInputSelect(invInputSelect), .eventPulse(eventPulse),
    .externalRefSelect(externalRefSelect),
    .bandgapSourceSelect(bandgapSourceSelect), .refPowerOn(refPowerOn),
    .refPinOutput(refPinOutput), .refSpanSelect(refSpanSelect),
    .refLevel(refLevel)
  );
  // Reference outputs packed in register order, unit 3 selects likewise
  assign refBits = {5'h00, externalRefSelect, bandgapSourceSelect,
    refPowerOn, refPinOutput, refSpanSelect, refLevel};
  assign ctlBits = {12'h000, resultPinOe[2], noninvInputSelect[2],
    invInputSelect[2]};
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    nTests++;
    if (got !== want) begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clock);
    regWrStb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] want);
    @(posedge clock);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clock);
    regRdStb <= 1'b0;
    #1;
    chk(regRdData, want);
  endtask : rd
  task automatic settle;
    repeat (8) @(posedge clock);
  endtask : settle
  task automatic wrapUp;
    $display("Checks %0d, mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrapUp
  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    $display("CHECK FAILED %0t watchdog", $time);
    wrapUp();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[3:0], 16'h0);
    wr(4'h0, 16'h1d2c);
    rd(4'h0, 16'h0);
    wr(4'h4, 16'hffff);
    rd(4'h4, 16'h07ff);
    chk(refBits, 16'h07ff);
    wr(4'h4, 16'h0249);
    #1 chk(refBits, 16'h0209);
    wr(4'h2, 16'h4013);
    #1 chk(ctlBits, 16'h000f);
    rd(4'h2, 16'h4013);
    wr(4'h2, 16'h0002);
    #1 chk(ctlBits, 16'h0002);
    wr(4'h3, 16'hffff);
    rd(4'h3, 16'h8000);
    wr(4'h0, 16'h8000);
    deviceIdle <= 1'b1;
    @(posedge clock);
    #1 chk({13'h0, compEnable}, 16'h0);
    wr(4'h3, 16'h0);
    #1 chk({13'h0, compEnable}, 16'h1);
    @(posedge clock);
    deviceIdle <= 1'b0;
    level <= 3'h1;
    settle();
    rd(4'h3, 16'h0001);
    rd(4'h0, 16'h8100);
    wr(4'h0, 16'ha000);
    level <= 3'h0;
    #5 chk({13'h0, resultPin}, 16'h1);
    settle();
    rd(4'h0, 16'ha100);
    wr(4'h0, 16'h0);
    // Each edge mode on unit 2: first hit, then rise, then fall
    for (int m = 0; m < 4; m++) begin
      c = 16'h8000 | 16'(m << 6);
      level <= 3'h2;
      wr(4'h1, 16'h8000);
      settle();
      wr(4'h1, c);
      settle();
      level <= 3'h0;
      settle();
      rd(4'h3, m != 0 ? 16'h0200 : 16'h0);
      wr(4'h1, c);
      level <= 3'h2;
      settle();
      rd(4'h3, m[0] ? 16'h0202 : 16'h0002);
      wr(4'h1, c);
      level <= 3'h0;
      settle();
      rd(4'h3, m[1] ? 16'h0200 : 16'h0);
      wr(4'h1, 16'h0);
    end
    // Unit 3: flag set by software, then one hardware event and its pulse
    wr(4'h2, 16'h0200);
    rd(4'h3, 16'h0400);
    rd(4'h2, 16'h0200);
    wr(4'h2, 16'h80c0);
    level <= 3'h4;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      #1 if (eventPulse[2]) hits++;
    end
    chk(16'(hits), 16'h0001);
    settle();
    rd(4'h3, 16'h0404);
    wrapUp();
  end
endmodule : tcc_triple_comparator_control_test
